/* File: src/clock_status_interrupt_regs.sv */
// Clock source selection, prescalers, ready status and interrupt registers of the clock unit.
//
// Contract
// - Two-bit source code picks slow, main, PLLs.
// - Prescale code n of 0 to 6 divides by two to n; code 7 stops the output.
// - Enable register: ones enable, zeros ignored.
// - Disable register: ones disable, zeros ignored.
// - All interrupt registers share one bit map.
// - Mask reads zero enabled, one disabled.
// - Status shows oscillator stabilised flag.
// - Status shows first PLL lock.
// - Status shows second PLL lock.
// - Status shows master clock ready.
// - Status shows which slow oscillator runs.
// - Status shows each programmable clock ready.
// - Oscillator stable after start count times eight.
// - Bypass sets stable; clearing both clears it.
// - PLL locks after programmed slow clock count.
`timescale 1ns/1ps
`default_nettype none
module clock_status_interrupt_regs #(
    parameter int NUM_PROG = clock_ctl_pkg::NUM_PROG
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire clock_ctl_pkg::bus_req_t bus,
    output logic [31:0] rdata_q,
    input wire logic slow_tick,
    input wire logic [3:0] source_tick,
    input wire logic slow_osc_external,
    output logic [NUM_PROG-1:0] prog_clock_tick_q,
    output logic master_tick_q,
    output logic irq_q
);
    localparam int NDIV = NUM_PROG + 1;
    localparam int MASTER = NUM_PROG;
    // Ready flags leave reset high; the edge detector starts there so no false event follows.
    localparam logic [31:0] FLAGS_AT_RESET = (32'h00000001 << clock_ctl_pkg::BIT_MASTER)
        | (((32'h00000001 << NUM_PROG) - 32'h00000001) << clock_ctl_pkg::BIT_PROG0);

    initial begin
        if (NUM_PROG < 1 || NUM_PROG > 4) $error("NUM_PROG must be 1 to 4");
    end

    // Configuration state.
    clock_ctl_pkg::clock_cfg_t cfg_q [NDIV];
    logic osc_enable_q;
    logic oscillator_bypass_q;
    logic [clock_ctl_pkg::OSC_COUNT_W-1:0] osc_count_q;
    logic [clock_ctl_pkg::PLL_COUNT_W-1:0] pll_a_lock_count_q;
    logic [clock_ctl_pkg::PLL_COUNT_W-1:0] pll_b_lock_count_q;
    logic [31:0] enable_q;
    logic [31:0] event_q;
    logic [31:0] flags_prev_q;
    logic [5:0] div_q [NDIV];
    logic [7:0] settle_q [NDIV];
    logic [NDIV-1:0] ready_q;
    logic [NDIV-1:0] tick_q;

    // Address decode of the register port.
    logic wr_osc;
    logic wr_pll_a;
    logic wr_pll_b;
    logic wr_enable;
    logic wr_disable;
    logic wr_event;
    logic [NDIV-1:0] wr_cfg;
    logic [31:0] wdata_flags;
    assign wr_osc = bus.wr && bus.addr == clock_ctl_pkg::OFF_OSC_CTRL;
    assign wr_pll_a = bus.wr && bus.addr == clock_ctl_pkg::OFF_PLL_A;
    assign wr_pll_b = bus.wr && bus.addr == clock_ctl_pkg::OFF_PLL_B;
    assign wr_enable = bus.wr && bus.addr == clock_ctl_pkg::OFF_IRQ_ENABLE;
    assign wr_disable = bus.wr && bus.addr == clock_ctl_pkg::OFF_IRQ_DISABLE;
    assign wr_event = bus.wr && bus.addr == clock_ctl_pkg::OFF_EVENT;
    assign wdata_flags = bus.wdata & clock_ctl_pkg::FLAG_MASK;

    // Oscillator control fields of the incoming write.
    logic new_osc_en;
    logic new_bypass;
    logic [clock_ctl_pkg::OSC_COUNT_W-1:0] new_osc_count;
    assign new_osc_en = bus.wdata[clock_ctl_pkg::OSC_EN_BIT];
    assign new_bypass = bus.wdata[clock_ctl_pkg::OSC_BYPASS_BIT];
    assign new_osc_count = bus.wdata[clock_ctl_pkg::OSC_COUNT_LSB +: clock_ctl_pkg::OSC_COUNT_W];

    // Oscillator start-up: the count is in units of eight slow clock cycles.
    logic osc_stable_flag;
    logic [clock_ctl_pkg::OSC_COUNT_W+2:0] osc_load;
    assign osc_load = {new_osc_count, 3'h0};
    lock_timer #(.W(clock_ctl_pkg::OSC_COUNT_W + clock_ctl_pkg::OSC_MULT_SHIFT)) osc_timer (
        .clock(clock),
        .rst_n(rst_n),
        .start(wr_osc && new_osc_en && !new_bypass),
        .set_now(wr_osc && new_bypass),
        .clear(wr_osc && !new_osc_en && !new_bypass),
        .load(osc_load),
        .tick(slow_tick),
        .done_q(osc_stable_flag)
    );

    // Each PLL relocks a programmed number of slow clock cycles after its register is written.
    logic pll_a_locked;
    logic pll_b_locked;
    lock_timer #(.W(clock_ctl_pkg::PLL_COUNT_W)) pll_a_timer (
        .clock(clock),
        .rst_n(rst_n),
        .start(wr_pll_a),
        .set_now(1'b0),
        .clear(1'b0),
        .load(bus.wdata[clock_ctl_pkg::PLL_COUNT_LSB +: clock_ctl_pkg::PLL_COUNT_W]),
        .tick(slow_tick),
        .done_q(pll_a_locked)
    );
    lock_timer #(.W(clock_ctl_pkg::PLL_COUNT_W)) pll_b_timer (
        .clock(clock),
        .rst_n(rst_n),
        .start(wr_pll_b),
        .set_now(1'b0),
        .clear(1'b0),
        .load(bus.wdata[clock_ctl_pkg::PLL_COUNT_LSB +: clock_ctl_pkg::PLL_COUNT_W]),
        .tick(slow_tick),
        .done_q(pll_b_locked)
    );

    // Plain copies of the oscillator and PLL controls, kept for read-back.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            osc_enable_q <= 1'b0;
            oscillator_bypass_q <= 1'b0;
            osc_count_q <= '0;
            pll_a_lock_count_q <= '0;
            pll_b_lock_count_q <= '0;
        end else begin
            if (wr_osc) begin
                osc_enable_q <= new_osc_en;
                oscillator_bypass_q <= new_bypass;
                osc_count_q <= new_osc_count;
            end
            if (wr_pll_a) begin
                pll_a_lock_count_q <= bus.wdata[clock_ctl_pkg::PLL_COUNT_LSB +:
                    clock_ctl_pkg::PLL_COUNT_W];
            end
            if (wr_pll_b) begin
                pll_b_lock_count_q <= bus.wdata[clock_ctl_pkg::PLL_COUNT_LSB +:
                    clock_ctl_pkg::PLL_COUNT_W];
            end
        end
    end

    // Dividers: slot MASTER is the master clock, the rest are the programmable outputs.
    genvar g;
    generate
        for (g = 0; g < NDIV; g++) begin : gen_div
            logic sel_tick;
            logic [5:0] div_mask;
            logic div_hit;
            logic reserved;
            assign wr_cfg[g] = bus.wr && bus.addr == ((g == MASTER) ?
                clock_ctl_pkg::OFF_MASTER_CLOCK :
                8'(clock_ctl_pkg::OFF_PROG_CLOCK0 + g * clock_ctl_pkg::PROG_STRIDE));
            assign sel_tick = source_tick[cfg_q[g].source_select];
            assign div_mask = 6'(7'(1) << cfg_q[g].prescale_code) - 6'h01;
            assign reserved = cfg_q[g].prescale_code == clock_ctl_pkg::PRESCALE_RESERVED;
            assign div_hit = sel_tick && !reserved && ((div_q[g] & div_mask) == div_mask);

            // A reserved code stops the output rather than guessing a ratio.
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    cfg_q[g] <= clock_ctl_pkg::CLOCK_CFG_RESET;
                    div_q[g] <= '0;
                    tick_q[g] <= 1'b0;
                end else begin
                    tick_q[g] <= div_hit;
                    if (wr_cfg[g]) begin
                        cfg_q[g] <= bus.wdata[clock_ctl_pkg::SRC_LSB +: 5];
                        div_q[g] <= '0;
                    end else if (sel_tick) begin
                        div_q[g] <= div_q[g] + 6'h01;
                    end
                end
            end

            // A new setting drops ready until the divider has settled on it.
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    settle_q[g] <= '0;
                    ready_q[g] <= 1'b1;
                end else if (wr_cfg[g]) begin
                    settle_q[g] <= clock_ctl_pkg::SETTLE_CYCLES;
                    ready_q[g] <= 1'b0;
                end else if (settle_q[g] != 8'h00) begin
                    settle_q[g] <= settle_q[g] - 8'h01;
                end else begin
                    ready_q[g] <= !reserved;
                end
            end
        end
    endgenerate

    // Live status word in the shared bit map; unassigned bits stay zero.
    logic [31:0] status_word;
    always_comb begin
        status_word = clock_ctl_pkg::READ_ZERO;
        status_word[clock_ctl_pkg::BIT_OSC] = osc_stable_flag;
        status_word[clock_ctl_pkg::BIT_PLL_A] = pll_a_locked;
        status_word[clock_ctl_pkg::BIT_PLL_B] = pll_b_locked;
        status_word[clock_ctl_pkg::BIT_MASTER] = ready_q[MASTER];
        status_word[clock_ctl_pkg::BIT_SLOW_OSC] = slow_osc_external;
        for (int i = 0; i < NUM_PROG; i++) begin
            status_word[clock_ctl_pkg::BIT_PROG0 + i] = ready_q[i];
        end
    end

    // Rising status flags are caught as sticky events; a new event wins over a clear.
    logic [31:0] flags;
    logic [31:0] rise;
    logic [31:0] event_d;
    logic [31:0] enable_d;
    assign flags = status_word & clock_ctl_pkg::FLAG_MASK;
    assign rise = flags & ~flags_prev_q;
    assign event_d = (event_q & ~(wr_event ? wdata_flags : 32'h00000000)) | rise;
    assign enable_d = (enable_q | (wr_enable ? wdata_flags : 32'h00000000))
        & ~(wr_disable ? wdata_flags : 32'h00000000);

    // Interrupt state; the output is registered so it never glitches.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= 32'h00000000;
            event_q <= 32'h00000000;
            flags_prev_q <= FLAGS_AT_RESET;
            irq_q <= 1'b0;
        end else begin
            enable_q <= enable_d;
            event_q <= event_d;
            flags_prev_q <= flags;
            irq_q <= |(event_q & enable_q);
        end
    end

    // Read multiplexer; write-only and unmapped addresses read as zero.
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = clock_ctl_pkg::READ_ZERO;
        for (int i = 0; i < NDIV; i++) begin
            if (bus.addr == ((i == MASTER) ? clock_ctl_pkg::OFF_MASTER_CLOCK :
                8'(clock_ctl_pkg::OFF_PROG_CLOCK0 + i * clock_ctl_pkg::PROG_STRIDE))) begin
                rd_mux = {27'h0000000, cfg_q[i]};
            end
        end
        unique case (bus.addr)
            clock_ctl_pkg::OFF_OSC_CTRL: begin
                rd_mux[clock_ctl_pkg::OSC_EN_BIT] = osc_enable_q;
                rd_mux[clock_ctl_pkg::OSC_BYPASS_BIT] = oscillator_bypass_q;
                rd_mux[clock_ctl_pkg::OSC_COUNT_LSB +: clock_ctl_pkg::OSC_COUNT_W] = osc_count_q;
            end
            clock_ctl_pkg::OFF_PLL_A: begin
                rd_mux[clock_ctl_pkg::PLL_COUNT_LSB +: clock_ctl_pkg::PLL_COUNT_W] =
                    pll_a_lock_count_q;
            end
            clock_ctl_pkg::OFF_PLL_B: begin
                rd_mux[clock_ctl_pkg::PLL_COUNT_LSB +: clock_ctl_pkg::PLL_COUNT_W] =
                    pll_b_lock_count_q;
            end
            clock_ctl_pkg::OFF_STATUS: rd_mux = status_word;
            clock_ctl_pkg::OFF_IRQ_MASK: rd_mux = ~enable_q & clock_ctl_pkg::FLAG_MASK;
            clock_ctl_pkg::OFF_EVENT: rd_mux = event_q;
            default: begin
            end
        endcase
    end

    // Read data stand in the cycle after the strobe only.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= bus.rd ? rd_mux : 32'h00000000;
        end
    end

    // Divided clock enables leave straight from flip-flops.
    assign prog_clock_tick_q = tick_q[NUM_PROG-1:0];
    assign master_tick_q = tick_q[MASTER];
endmodule // clock_status_interrupt_regs
`default_nettype wire

/* File: src/clock_ctl_pkg.sv */
// Package with the register map, field layout and carrier types of the clock status block.
package clock_ctl_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_PROG = 4;

    // Byte offsets of the registers.
    localparam logic [7:0] OFF_PROG_CLOCK0 = 8'h00;
    localparam logic [7:0] PROG_STRIDE = 8'h04;
    localparam logic [7:0] OFF_OSC_CTRL = 8'h20;
    localparam logic [7:0] OFF_PLL_A = 8'h28;
    localparam logic [7:0] OFF_PLL_B = 8'h2C;
    localparam logic [7:0] OFF_MASTER_CLOCK = 8'h30;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h60;
    localparam logic [7:0] OFF_IRQ_DISABLE = 8'h64;
    localparam logic [7:0] OFF_STATUS = 8'h68;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h6C;
    localparam logic [7:0] OFF_EVENT = 8'h70;

    // Field positions inside the configuration registers.
    localparam int SRC_LSB = 0;
    localparam int PRESCALE_LSB = 2;
    localparam int OSC_EN_BIT = 0;
    localparam int OSC_BYPASS_BIT = 1;
    localparam int OSC_COUNT_LSB = 8;
    localparam int OSC_COUNT_W = 8;
    localparam int OSC_MULT_SHIFT = 3;
    localparam int PLL_COUNT_LSB = 8;
    localparam int PLL_COUNT_W = 6;

    // Shared bit map of status, enable, disable, mask and event registers.
    localparam int BIT_OSC = 0;
    localparam int BIT_PLL_A = 1;
    localparam int BIT_PLL_B = 2;
    localparam int BIT_MASTER = 3;
    localparam int BIT_SLOW_OSC = 7;
    localparam int BIT_PROG0 = 8;
    localparam logic [31:0] FLAG_MASK = 32'h00000F0F;

    // Reset values and timing counts.
    localparam logic [2:0] PRESCALE_RESERVED = 3'h7;
    localparam logic [4:0] CLOCK_CFG_RESET = 5'h00;
    localparam logic [7:0] SETTLE_CYCLES = 8'h04;
    localparam logic [31:0] READ_ZERO = 32'h00000000;

    typedef enum logic [1:0] {
        SRC_SLOW,
        SRC_MAIN,
        SRC_PLL_A,
        SRC_PLL_B
    } source_t;

    typedef struct packed {
        logic [2:0] prescale_code;
        source_t source_select;
    } clock_cfg_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;
endpackage

/* File: src/lock_timer.sv */
// Down-counter that raises a ready flag a programmed number of slow clock ticks after a start.
`timescale 1ns/1ps
`default_nettype none
module lock_timer #(
    parameter int W = 11
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    input wire logic set_now,
    input wire logic clear,
    input wire logic [W-1:0] load,
    input wire logic tick,
    output logic done_q
);
    logic [W-1:0] count_q;
    logic busy_q;

    initial begin
        if (W < 1 || W > 16) $error("lock_timer width out of range");
    end

    // A start with a zero count completes at once; a clear wins over everything.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (clear) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (set_now || (start && load == '0)) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
        end else if (start) begin
            count_q <= load;
            busy_q <= 1'b1;
            done_q <= 1'b0;
        end else if (busy_q && tick) begin
            count_q <= count_q - 1'b1;
            if (count_q == W'(1)) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
            end
        end
    end
endmodule // lock_timer
`default_nettype wire

/* File: test/status_irq_asserts.sv */
// Checker for read answers, mask polarity, interrupt gating and divider ticks.
`timescale 1ns/1ps
`default_nettype none
module status_irq_asserts #(
    parameter int NUM_PROG = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire clock_ctl_pkg::bus_req_t bus,
    input wire logic [31:0] rdata_q,
    input wire logic slow_tick,
    input wire logic [3:0] source_tick,
    input wire logic slow_osc_external,
    input wire logic [NUM_PROG-1:0] prog_clock_tick_q,
    input wire logic master_tick_q,
    input wire logic irq_q
);
    // Decoded accesses keep the properties short.
    wire logic rd_st = bus.rd && bus.addr == clock_ctl_pkg::OFF_STATUS;
    wire logic rd_mk = bus.rd && bus.addr == clock_ctl_pkg::OFF_IRQ_MASK;
    wire logic rd_en = bus.rd && bus.addr == clock_ctl_pkg::OFF_IRQ_ENABLE;
    wire logic rd_dis = bus.rd && bus.addr == clock_ctl_pkg::OFF_IRQ_DISABLE;
    wire logic wr_en = bus.wr && bus.addr == clock_ctl_pkg::OFF_IRQ_ENABLE;
    wire logic wr_dis = bus.wr && bus.addr == clock_ctl_pkg::OFF_IRQ_DISABLE;
    wire logic dis_all = wr_dis && (bus.wdata & clock_ctl_pkg::FLAG_MASK) == 32'h00000F0F;

    // One clock domain, so clocking and reset are given once.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_read_idle_zero: assert property (!bus.rd |=> rdata_q == 32'h00000000)
        else $error("read data not zero outside a read");
    a_osc_choice_shown: assert property (rd_st && $stable(slow_osc_external)
        |=> rdata_q[7] == $past(slow_osc_external)) else $error("slow oscillator choice wrong");
    a_status_spare_zero: assert property (rd_st |=> (rdata_q & 32'hFFFFF070) == 32'h0)
        else $error("status spare bits not zero");
    a_mask_spare_zero: assert property (rd_mk |=> (rdata_q & 32'hFFFFF0F0) == 32'h0)
        else $error("mask spare bits not zero");
    a_wo_read_zero: assert property (rd_en || rd_dis |=> rdata_q == 32'h0)
        else $error("write-only register read not zero");
    a_unmapped_zero: assert property (bus.rd && bus.addr == 8'h80 |=> rdata_q == 32'h0)
        else $error("unmapped read not zero");
    a_mask_after_enable: assert property (wr_en && bus.wdata[0]
        ##1 !(wr_dis && bus.wdata[0]) ##1 rd_mk |=> !rdata_q[0])
        else $error("mask bit not clear after enable");
    a_mask_after_disable: assert property (wr_dis && bus.wdata[0]
        ##1 !(wr_en && bus.wdata[0]) ##1 rd_mk |=> rdata_q[0])
        else $error("mask bit not set after disable");
    a_irq_off_disabled: assert property (dis_all |-> ##2 !irq_q)
        else $error("interrupt high with all sources disabled");
    a_tick_from_source: assert property ((prog_clock_tick_q != 0) || master_tick_q
        |-> $past(source_tick) != 4'h0) else $error("divided tick without a source tick");

    // Main scenarios that the bench should reach.
    c_irq_rise: cover property ($rose(irq_q));
    c_master_tick: cover property (master_tick_q);
    c_prog_tick: cover property (prog_clock_tick_q[0]);
endmodule // status_irq_asserts

bind clock_status_interrupt_regs status_irq_asserts #(.NUM_PROG(NUM_PROG)) i_chk (
    .clock(clock),
    .rst_n(rst_n),
    .bus(bus),
    .rdata_q(rdata_q),
    .slow_tick(slow_tick),
    .source_tick(source_tick),
    .slow_osc_external(slow_osc_external),
    .prog_clock_tick_q(prog_clock_tick_q),
    .master_tick_q(master_tick_q),
    .irq_q(irq_q)
);
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the clock status and interrupt register block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    clock_ctl_pkg::bus_req_t bus = '0;
    logic [31:0] rdata_q;
    logic slow_tick = 1'b0;
    logic [3:0] source_tick = 4'h0;
    logic slow_osc_external = 1'b1;
    logic [3:0] prog_clock_tick_q;
    logic master_tick_q;
    logic irq_q;
    logic [31:0] d;
    int error_cnt = 0;
    int checks = 0;
    int tick_cnt = 0;
    int ch = 0;

    // Clock of 50 ns period.
    always #25 clock = ~clock;

    // Pulses are counted mid-cycle, where the outputs have settled; tests take differences.
    always @(negedge clock) begin
        tick_cnt <= tick_cnt + ((ch == 4) ? master_tick_q : prog_clock_tick_q[ch[1:0]]);
    end

    clock_status_interrupt_regs #(.NUM_PROG(4)) i_dut (
        .clock(clock),
        .rst_n(rst_n),
        .bus(bus),
        .rdata_q(rdata_q),
        .slow_tick(slow_tick),
        .source_tick(source_tick),
        .slow_osc_external(slow_osc_external),
        .prog_clock_tick_q(prog_clock_tick_q),
        .master_tick_q(master_tick_q),
        .irq_q(irq_q)
    );

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Each access leaves one idle cycle, so a strobe is never assigned twice in a step.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clock);
        bus <= '0;
        @(posedge clock);
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken just then.
    task automatic rd(input logic [7:0] a, input string name, input logic [31:0] exp);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clock);
        bus <= '0;
        #1 d = rdata_q;
        chk(name, exp, d);
        @(posedge clock);
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            slow_tick <= 1'b1;
            @(posedge clock);
            slow_tick <= 1'b0;
            @(posedge clock);
        end
    endtask

    // Waits until the registered interrupt has settled, then looks at it mid-cycle.
    task automatic irq_chk(input logic e);
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk("irq", {31'h0, e}, {31'h0, irq_q});
        @(posedge clock);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // The whole run is near 1,250 cycles, so this limit only trips on a hang.
    initial begin
        repeat (10000) @(posedge clock);
        error_cnt++;
        finish_test();
    end

    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(clock_ctl_pkg::OFF_STATUS, "status", 32'h00000F88);
        rd(clock_ctl_pkg::OFF_IRQ_MASK, "mask", 32'h00000F0F);
        rd(8'h80, "unmapped", 32'h0);
        $display("test reset done");
        wr(clock_ctl_pkg::OFF_IRQ_ENABLE, 32'hFFFFFFFF);
        rd(clock_ctl_pkg::OFF_IRQ_MASK, "mask", 32'h0);
        rd(clock_ctl_pkg::OFF_IRQ_ENABLE, "enable", 32'h0);
        wr(clock_ctl_pkg::OFF_IRQ_DISABLE, 32'h00000105);
        rd(clock_ctl_pkg::OFF_IRQ_MASK, "mask", 32'h00000105);
        wr(clock_ctl_pkg::OFF_IRQ_ENABLE, 32'h0);
        wr(clock_ctl_pkg::OFF_IRQ_DISABLE, 32'h0);
        rd(clock_ctl_pkg::OFF_IRQ_MASK, "mask", 32'h00000105);
        rd(clock_ctl_pkg::OFF_IRQ_DISABLE, "disable", 32'h0);
        wr(clock_ctl_pkg::OFF_IRQ_DISABLE, 32'hFFFFFFFF);
        rd(clock_ctl_pkg::OFF_IRQ_MASK, "mask", 32'h00000F0F);
        slow_osc_external <= 1'b0;
        $display("test irq registers done");
        wr(clock_ctl_pkg::OFF_OSC_CTRL, 32'h00000002);
        rd(clock_ctl_pkg::OFF_STATUS, "status", 32'h00000F09);
        wr(clock_ctl_pkg::OFF_OSC_CTRL, 32'h0);
        rd(clock_ctl_pkg::OFF_STATUS, "status", 32'h00000F08);
        wr(clock_ctl_pkg::OFF_OSC_CTRL, 32'h00000101);
        ticks(7);
        rd(clock_ctl_pkg::OFF_STATUS, "status", 32'h00000F08);
        ticks(1);
        rd(clock_ctl_pkg::OFF_STATUS, "status", 32'h00000F09);
        wr(clock_ctl_pkg::OFF_PLL_A, 32'h00000300);
        ticks(2);
        rd(clock_ctl_pkg::OFF_STATUS, "status", 32'h00000F09);
        ticks(1);
        rd(clock_ctl_pkg::OFF_STATUS, "status", 32'h00000F0B);
        wr(clock_ctl_pkg::OFF_PLL_B, 32'h00000100);
        rd(clock_ctl_pkg::OFF_STATUS, "status", 32'h00000F0B);
        ticks(1);
        rd(clock_ctl_pkg::OFF_STATUS, "status", 32'h00000F0F);
        $display("test oscillator and lock done");
        irq_chk(1'b0);
        rd(clock_ctl_pkg::OFF_EVENT, "event", 32'h00000007);
        chk("event", 32'h7, d & 32'h7);
        wr(clock_ctl_pkg::OFF_EVENT, 32'hFFFFFFFF);
        rd(clock_ctl_pkg::OFF_EVENT, "event", 32'h0);
        wr(clock_ctl_pkg::OFF_IRQ_ENABLE, 32'h00000002);
        irq_chk(1'b0);
        wr(clock_ctl_pkg::OFF_PLL_A, 32'h00000100);
        ticks(1);
        irq_chk(1'b1);
        wr(clock_ctl_pkg::OFF_IRQ_DISABLE, 32'hFFFFFFFF);
        irq_chk(1'b0);
        wr(clock_ctl_pkg::OFF_IRQ_ENABLE, 32'h00000002);
        irq_chk(1'b1);
        wr(clock_ctl_pkg::OFF_EVENT, 32'h00000002);
        irq_chk(1'b0);
        $display("test interrupt done");
        // Every prescale code on a rotating output and source; other sources stay quiet.
        for (int c = 0; c < 8; c++) begin
            int b0;
            ch = c % 5;
            wr((ch == 4) ? clock_ctl_pkg::OFF_MASTER_CLOCK : 8'(ch * 4), 32'(c * 4 + c % 4));
            repeat (6) @(posedge clock);
            rd(clock_ctl_pkg::OFF_STATUS, "status",
                (c == 7) ? 32'h00000B0F : 32'h00000F0F);
            chk("ready", {31'h0, c != 7}, {31'h0, d[(ch == 4) ? 3 : 8 + ch]});
            b0 = tick_cnt;
            source_tick <= 4'(1 << (c % 4));
            repeat (128) @(posedge clock);
            source_tick <= 4'h0;
            repeat (3) @(posedge clock);
            chk("ticks", (c == 7) ? 32'h0 : 32'(128 >> c), 32'(tick_cnt - b0));
        end
        $display("test dividers done");
        finish_test();
    end
endmodule // testbench
`default_nettype wire
